// File: common/lrt_pkg.sv
`default_nettype none
package lrt_pkg;
	// Register byte offsets on the AXI4-Lite slave
	localparam logic [31:0] LRT_OFF_CTRL = 32'h0000_0000;
	localparam logic [31:0] LRT_OFF_PORTCFG = 32'h0000_0004;
	localparam logic [31:0] LRT_OFF_STATUS = 32'h0000_0008;
	// Control register fields
	localparam int LRT_CTRL_W = 5;
	localparam int LRT_B_MON = 0;
	localparam int LRT_B_RXTRI = 1;
	localparam int LRT_B_IPTRI = 2;
	localparam int LRT_B_TXTRI = 3;
	localparam int LRT_B_TERM = 4;
	// Port configuration fields, four bits each
	localparam int LRT_PCFG_W = 12;
	localparam int LRT_FN_W = 4;
	localparam int LRT_F_XPC = 0;
	localparam int LRT_F_RPC1 = 4;
	localparam int LRT_F_RPC2 = 8;
	// Port function codes
	localparam logic [3:0] LRT_FN_XLT_HI = 4'h8;
	localparam logic [3:0] LRT_FN_XLT_LO = 4'hE;
	localparam logic [3:0] LRT_FN_RX_TRI = 4'hD;
	localparam logic [3:0] LRT_FN_TERM = 4'h8;
	// Status register fields
	localparam int LRT_S_RXTRI = 0;
	localparam int LRT_S_TXTRI = 1;
	localparam int LRT_S_TERM = 2;
	localparam int LRT_S_MON = 3;
	localparam int LRT_S_PINS = 4;
	// Synchronised pin order
	localparam int LRT_P_RPA1 = 0;
	localparam int LRT_P_RPA2 = 1;
	localparam int LRT_P_XPA = 2;
	localparam int LRT_NPINS = 3;
	// Monitoring mode sensitivity, in dB of resistive attenuation
	localparam int LRT_MON_SENS_DB = -20;
	// AXI responses
	localparam logic [1:0] LRT_RESP_OKAY = 2'h0;
	localparam logic [1:0] LRT_RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic awvalid;
		logic [31:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [31:0] araddr;
		logic rready;
	} lrt_axi_req_s;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} lrt_axi_rsp_s;

	typedef struct packed {
		logic rdata;
		logic rdata_oe_n;
		logic rdata_pullup;
		logic fclk_oe_n;
		logic tx_oe_n;
		logic term_on;
		logic monitor;
	} lrt_pins_s;

	typedef struct packed {
		lrt_axi_rsp_s rsp;
		logic aw_got;
		logic w_got;
		logic [31:0] waddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic [LRT_CTRL_W-1:0] ctrl;
		logic [LRT_PCFG_W-1:0] portcfg;
		logic [LRT_NPINS-1:0] meta;
		logic [LRT_NPINS-1:0] sync;
		lrt_pins_s pins;
	} lrt_state_s;

	// Line-facing pins come out of reset in high impedance
	localparam lrt_state_s LRT_STATE_RST = '{
		pins: '{rdata_oe_n: 1'h1, fclk_oe_n: 1'h1, tx_oe_n: 1'h1,
			default: 1'h0},
		default: '0};
endpackage
`default_nettype wire

// File: hdl/lrt_line_ctrl.sv
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module lrt_line_ctrl (
	input wire logic I_CLOCK,
	input wire logic I_RESETN,
	input wire lrt_pkg::lrt_axi_req_s I_AXI,
	output var lrt_pkg::lrt_axi_rsp_s O_AXI,
	input wire logic I_XPA_PIN,
	input wire logic I_RPA1_PIN,
	input wire logic I_RPA2_PIN,
	input wire logic I_RX_DATA,
	input wire logic I_CHANNEL_INACTIVE,
	output var lrt_pkg::lrt_pins_s O_PINS
);
	import lrt_pkg::*;

	lrt_state_s q;
	lrt_state_s d;

	logic rx_tri_sel1;
	logic rx_tri_sel2;
	logic rx_tri_pin;
	logic eff_rx_tri;
	logic xlt_in;
	logic tx_tri;
	logic term_sel1;
	logic term_sel2;
	logic term_on;
	logic [3:0] xpc;
	logic [31:0] wmerge;
	logic [31:0] rword;
	logic rhit;
	logic whit;

	// Port function decode; port 1 wins if both receive ports claim a function
	assign xpc = q.portcfg[LRT_F_XPC +: LRT_FN_W];
	assign rx_tri_sel1 = q.portcfg[LRT_F_RPC1 +: LRT_FN_W] == LRT_FN_RX_TRI;
	assign rx_tri_sel2 = q.portcfg[LRT_F_RPC2 +: LRT_FN_W] == LRT_FN_RX_TRI;
	assign term_sel1 = q.portcfg[LRT_F_RPC1 +: LRT_FN_W] == LRT_FN_TERM;
	assign term_sel2 = q.portcfg[LRT_F_RPC2 +: LRT_FN_W] == LRT_FN_TERM;

	// Receive-side tristate control from pin and register bit
	assign rx_tri_pin = rx_tri_sel1 ? q.sync[LRT_P_RPA1] :
		(rx_tri_sel2 ? q.sync[LRT_P_RPA2] : 1'h0);
	assign eff_rx_tri = q.ctrl[LRT_B_RXTRI] ^ rx_tri_pin;

	// Transmit tristate input, polarity chosen by the port field
	always_comb begin
		case (xpc)
			LRT_FN_XLT_HI: xlt_in = q.sync[LRT_P_XPA];
			LRT_FN_XLT_LO: xlt_in = ~q.sync[LRT_P_XPA];
			default: xlt_in = 1'h0;
		endcase
	end
	assign tx_tri = q.ctrl[LRT_B_TXTRI] | xlt_in;

	// Equivalence turns the switch on for bit 0 and a low board signal
	assign term_on = term_sel1 ? ~(q.sync[LRT_P_RPA1] ^ q.ctrl[LRT_B_TERM]) :
		(term_sel2 ? ~(q.sync[LRT_P_RPA2] ^ q.ctrl[LRT_B_TERM]) :
		q.ctrl[LRT_B_TERM]);

	// Read decode; status shows live combined controls
	always_comb begin
		rword = 32'h0000_0000;
		rhit = 1'h1;
		case (I_AXI.araddr)
			LRT_OFF_CTRL: rword[LRT_CTRL_W-1:0] = q.ctrl;
			LRT_OFF_PORTCFG: rword[LRT_PCFG_W-1:0] = q.portcfg;
			LRT_OFF_STATUS: begin
				rword[LRT_S_RXTRI] = eff_rx_tri;
				rword[LRT_S_TXTRI] = tx_tri;
				rword[LRT_S_TERM] = term_on;
				rword[LRT_S_MON] = q.ctrl[LRT_B_MON];
				rword[LRT_S_PINS +: LRT_NPINS] = q.sync;
			end
			default: rhit = 1'h0;
		endcase
	end

	// Byte-lane merge of the held write onto the addressed register
	always_comb begin
		wmerge = 32'h0000_0000;
		whit = 1'h1;
		case (q.waddr)
			LRT_OFF_CTRL: wmerge[LRT_CTRL_W-1:0] = q.ctrl;
			LRT_OFF_PORTCFG: wmerge[LRT_PCFG_W-1:0] = q.portcfg;
			default: whit = 1'h0;
		endcase
		for (int b = 0; b < 4; b++) begin
			if (q.wstrb[b]) begin
				wmerge[b*8 +: 8] = q.wdata[b*8 +: 8];
			end
		end
	end

	// Next state: synchronisers, AXI slave, registered pin controls
	always_comb begin
		d = q;
		// First stage feeds only the second stage
		d.meta[LRT_P_RPA1] = I_RPA1_PIN;
		d.meta[LRT_P_RPA2] = I_RPA2_PIN;
		d.meta[LRT_P_XPA] = I_XPA_PIN;
		d.sync = q.meta;

		// Address and data may arrive in either order
		if (I_AXI.awvalid && q.rsp.awready) begin
			d.aw_got = 1'h1;
			d.waddr = I_AXI.awaddr;
		end
		if (I_AXI.wvalid && q.rsp.wready) begin
			d.w_got = 1'h1;
			d.wdata = I_AXI.wdata;
			d.wstrb = I_AXI.wstrb;
		end
		if (q.aw_got && q.w_got && !q.rsp.bvalid) begin
			d.aw_got = 1'h0;
			d.w_got = 1'h0;
			d.rsp.bvalid = 1'h1;
			// Status is read-only; writes to it are refused
			d.rsp.bresp = (whit) ? LRT_RESP_OKAY : LRT_RESP_SLVERR;
			if (q.waddr == LRT_OFF_CTRL) begin
				d.ctrl = wmerge[LRT_CTRL_W-1:0];
			end
			if (q.waddr == LRT_OFF_PORTCFG) begin
				d.portcfg = wmerge[LRT_PCFG_W-1:0];
			end
		end
		if (q.rsp.bvalid && I_AXI.bready) begin
			d.rsp.bvalid = 1'h0;
		end
		d.rsp.awready = !d.aw_got && !d.rsp.bvalid;
		d.rsp.wready = !d.w_got && !d.rsp.bvalid;

		// Read channel, one read in flight
		if (q.rsp.rvalid && I_AXI.rready) begin
			d.rsp.rvalid = 1'h0;
		end
		if (I_AXI.arvalid && q.rsp.arready) begin
			d.rsp.rvalid = 1'h1;
			d.rsp.rdata = rword;
			d.rsp.rresp = (rhit) ? LRT_RESP_OKAY : LRT_RESP_SLVERR;
		end
		d.rsp.arready = !d.rsp.rvalid;

		// Pin controls; the output flop is the only stage after sync
		d.pins.rdata = I_RX_DATA;
		d.pins.monitor = q.ctrl[LRT_B_MON];
		if (eff_rx_tri) begin
			d.pins.rdata_oe_n = 1'h1;
			d.pins.rdata_pullup = 1'h0;
		end else if (q.ctrl[LRT_B_IPTRI] && I_CHANNEL_INACTIVE) begin
			d.pins.rdata_oe_n = 1'h1;
			d.pins.rdata_pullup = 1'h1;
		end else begin
			d.pins.rdata_oe_n = 1'h0;
			d.pins.rdata_pullup = 1'h0;
		end
		d.pins.fclk_oe_n = eff_rx_tri;
		d.pins.tx_oe_n = tx_tri;
		d.pins.term_on = term_on;
	end

	// Single state register, synchronous reset
	always_ff @(posedge I_CLOCK) begin
		if (!I_RESETN) begin
			q <= LRT_STATE_RST;
		end else begin
			q <= d;
		end
	end

	assign O_AXI = q.rsp;
	assign O_PINS = q.pins;

	default clocking cb @(posedge I_CLOCK); endclocking
	default disable iff (!I_RESETN);

	// Register write completes with a response, then steers logic
	sequence s_wr_commit;
		q.aw_got && q.w_got && !q.rsp.bvalid && q.waddr == LRT_OFF_CTRL;
	endsequence
	sequence s_wr_resp;
		q.rsp.bvalid && q.rsp.bresp == LRT_RESP_OKAY;
	endsequence

	property p_mon_follows;
		s_wr_commit ##1 s_wr_resp |=> O_PINS.monitor == $past(q.ctrl[LRT_B_MON]);
	endproperty
	a_mon_follows: assert property (p_mon_follows)
		else $error("monitor output not following written enable");

	property p_rx_xor;
		rx_tri_sel1 && $stable(q.ctrl) |=>
			O_PINS.fclk_oe_n == ($past(q.meta[LRT_P_RPA1], 2) ^
			$past(q.ctrl[LRT_B_RXTRI]));
	endproperty
	a_rx_xor: assert property (p_rx_xor)
		else $error("receive tristate is not pin xor bit");

	property p_rx_reg_only;
		!rx_tri_sel1 && !rx_tri_sel2 && q.ctrl[LRT_B_RXTRI] |=>
			O_PINS.rdata_oe_n && O_PINS.fclk_oe_n;
	endproperty
	a_rx_reg_only: assert property (p_rx_reg_only)
		else $error("register bit alone failed to tristate outputs");

	property p_rx_float;
		eff_rx_tri |=> O_PINS.rdata_oe_n && O_PINS.fclk_oe_n &&
			!O_PINS.rdata_pullup;
	endproperty
	a_rx_float: assert property (p_rx_float)
		else $error("receive pins not floating without pulls");

	property p_inactive_pullup;
		!eff_rx_tri && q.ctrl[LRT_B_IPTRI] |=>
			O_PINS.rdata_oe_n == $past(I_CHANNEL_INACTIVE) &&
			O_PINS.rdata_pullup == $past(I_CHANNEL_INACTIVE) &&
			!O_PINS.fclk_oe_n;
	endproperty
	a_inactive_pullup: assert property (p_inactive_pullup)
		else $error("inactive phase tristate wrong");

	property p_never_tri;
		!eff_rx_tri && !q.ctrl[LRT_B_IPTRI] |=>
			!O_PINS.rdata_oe_n && !O_PINS.fclk_oe_n;
	endproperty
	a_never_tri: assert property (p_never_tri)
		else $error("receive pins tristated while always driven");

	property p_xlt_low;
		xpc == LRT_FN_XLT_LO && !q.ctrl[LRT_B_TXTRI] && $stable(xpc) |=>
			O_PINS.tx_oe_n == !$past(q.meta[LRT_P_XPA], 2);
	endproperty
	a_xlt_low: assert property (p_xlt_low)
		else $error("active-low transmit tristate input wrong");

	property p_tx_or;
		q.ctrl[LRT_B_TXTRI] || (xpc == LRT_FN_XLT_HI && q.sync[LRT_P_XPA])
			|=> O_PINS.tx_oe_n;
	endproperty
	a_tx_or: assert property (p_tx_or)
		else $error("transmit drivers not tristated");

	property p_term_xnor;
		term_sel1 |=> O_PINS.term_on ==
			!($past(q.sync[LRT_P_RPA1]) ^ $past(q.ctrl[LRT_B_TERM]));
	endproperty
	a_term_xnor: assert property (p_term_xnor)
		else $error("termination switch not pin xnor bit");

	property p_latency;
		$changed(q.sync[LRT_P_XPA]) && xpc == LRT_FN_XLT_HI &&
			!q.ctrl[LRT_B_TXTRI] &&
			$stable(q.ctrl) && $stable(xpc) |=> $changed(O_PINS.tx_oe_n);
	endproperty
	a_latency: assert property (p_latency)
		else $error("transmit tristate lagged the synchronised pin");
endmodule // lrt_line_ctrl
`default_nettype wire

// File: tb/lrt_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// Board logic beside one channel: framer data source and switch signals
module lrt_far_model (
	input wire logic i_clock,
	input wire logic [2:0] i_sel,
	input wire logic i_inactive,
	output logic o_xpa,
	output logic o_rpa1,
	output logic o_rpa2,
	output logic o_rx_data,
	output logic o_inactive
);
	logic [7:0] lfsr_ff = 8'h01;
	logic [3:0] pins_ff = 4'h0;
	// Everything moves just after an edge, as real board logic would
	always @(posedge i_clock) begin
		lfsr_ff <= {lfsr_ff[6:0], ^(lfsr_ff & 8'hB8)};
		pins_ff <= {i_inactive, i_sel};
	end
	// One board signal may feed all three pins, so only one twin drives
	assign {o_inactive, o_xpa, o_rpa2, o_rpa1} = pins_ff;
	assign o_rx_data = lfsr_ff[7];
endmodule // lrt_far_model
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import lrt_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	lrt_axi_req_s req = '0;
	lrt_axi_rsp_s rsp;
	lrt_pins_s pins;
	logic [2:0] far_sel = 3'h0;
	logic far_inact = 1'b0;
	logic transmit_multifunction_pin, rpa1, rpa2, rxd, inact;
	int num_errors = 0;
	int total_checks = 0;
	int seed = 50;
	logic [1:0] resp;
	logic [31:0] rdat;
	logic [3:0] codes [4] = '{4'h8, 4'hE, 4'hD, 4'h0};

	// 50 MHz
	always #10 clk = ~clk;

	lrt_line_ctrl u_dut (.I_CLOCK(clk), .I_RESETN(rst_n), .I_AXI(req),
		.O_AXI(rsp), .I_XPA_PIN(transmit_multifunction_pin), .I_RPA1_PIN(rpa1),
		.I_RPA2_PIN(rpa2), .I_RX_DATA(rxd), .I_CHANNEL_INACTIVE(inact),
		.O_PINS(pins));
	lrt_far_model u_far (.i_clock(clk), .i_sel(far_sel),
		.i_inactive(far_inact), .o_xpa(transmit_multifunction_pin), .o_rpa1(rpa1),
		.o_rpa2(rpa2), .o_rx_data(rxd), .o_inactive(inact));

	task automatic complete_run;
		$display("errors %0d checks %0d", num_errors, total_checks);
		if (num_errors == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] s);
		total_checks++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask

	// A wait that runs out is a failure and ends the run
	task automatic limit(input int n);
		if (n >= 100) begin
			$display("CHECK FAILED bus wait expected answer seen none");
			num_errors++;
			complete_run();
		end
	endtask

	// Write: address and data offered together, each dropped once taken
	task automatic axw(input logic [31:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= 4'hF;
		req.bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge clk);
			if (rsp.awready && req.awvalid)
				req.awvalid <= 1'b0;
			if (rsp.wready && req.wvalid)
				req.wvalid <= 1'b0;
			if (rsp.bvalid)
				break;
		end
		limit(n);
		req.bready <= 1'b0;
		resp = rsp.bresp;
	endtask

	task automatic axr(input logic [31:0] a);
		int n;
		@(posedge clk);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge clk);
			if (rsp.arready && req.arvalid)
				req.arvalid <= 1'b0;
			if (rsp.rvalid)
				break;
		end
		limit(n);
		req.rready <= 1'b0;
		resp = rsp.rresp;
		rdat = rsp.rdata;
	endtask

	// Expected {tx_oe_n, term_on, monitor, rdata_oe_n, pullup, fclk_oe_n}
	function automatic logic [5:0] exp_f(input logic [4:0] c,
		input logic [11:0] p, input logic [2:0] s, input logic ina);
		logic eff, term, tx;
		eff = c[LRT_B_RXTRI];
		if (p[7:4] == LRT_FN_RX_TRI)
			eff = eff ^ s[0];
		else if (p[11:8] == LRT_FN_RX_TRI)
			eff = eff ^ s[1];
		term = c[LRT_B_TERM];
		if (p[7:4] == LRT_FN_TERM)
			term = ~(term ^ s[0]);
		else if (p[11:8] == LRT_FN_TERM)
			term = ~(term ^ s[1]);
		tx = c[LRT_B_TXTRI] | (p[3:0] == LRT_FN_XLT_HI && s[2])
			| (p[3:0] == LRT_FN_XLT_LO && !s[2]);
		return {tx, term, c[LRT_B_MON], eff | (c[LRT_B_IPTRI] & ina),
			~eff & c[LRT_B_IPTRI] & ina, eff};
	endfunction

	// Program, move the pins, let the synchronisers settle, then compare
	task automatic run_case(input logic [4:0] c, input logic [11:0] p,
		input logic [2:0] s, input logic ina);
		logic [5:0] e;
		logic rx_prev;
		axw(LRT_OFF_CTRL, {27'h0, c});
		axw(LRT_OFF_PORTCFG, {20'h0_0000, p});
		far_sel <= s;
		far_inact <= ina;
		repeat (5) @(posedge clk);
		// Data sampled at this edge shows on the pin after it
		rx_prev = rxd;
		@(posedge clk);
		chk("rdata", rx_prev, pins.rdata);
		e = exp_f(c, p, s, ina);
		chk("tx_oe_n", e[5], pins.tx_oe_n);
		chk("term_on", e[4], pins.term_on);
		chk("monitor", e[3], pins.monitor);
		chk("rx_pins", e[2:0],
			{pins.rdata_oe_n, pins.rdata_pullup, pins.fclk_oe_n});
		axr(LRT_OFF_STATUS);
		chk("status", {25'h0, s, e[3], e[4], e[5], e[0]}, rdat);
	endtask

	initial begin
		logic [11:0] p;
		repeat (3) @(posedge clk);
		chk("reset_pins", LRT_STATE_RST.pins, pins);
		rst_n <= 1'b1;
		// Status is read only and stray addresses are refused
		axw(LRT_OFF_STATUS, 32'h0000_001F);
		chk("status_wr_resp", LRT_RESP_SLVERR, resp);
		axw(32'h0000_0010, 32'h0000_0001);
		chk("unmapped_wr_resp", LRT_RESP_SLVERR, resp);
		axr(32'h0000_0010);
		chk("unmapped_rd", {LRT_RESP_SLVERR, 32'h0}, {resp, rdat});
		// Twin channels on one board signal, both signal levels
		for (int k = 0; k < 4; k++)
			run_case(k[0] ? 5'h03 : 5'h00, k[0] ? 12'h8DE : 12'h8D8,
				{3{k[1]}}, k[0]);
		// Random mixes of every port code, bits and pin levels
		for (int k = 0; k < 40; k++) begin
			p = {codes[$unsigned($random(seed)) % 4],
				codes[$unsigned($random(seed)) % 4],
				codes[$unsigned($random(seed)) % 4]};
			run_case(5'($random(seed)), p, 3'($random(seed)),
				1'($random(seed)));
		end
		complete_run();
	end
endmodule // tb
`default_nettype wire
